/* File: slpc_pkg.sv */
// slpc_pkg: offsets, field positions, reset values and carrier types of the
// serial link parameter configuration bank.
// assumes: included before slpc_param_bank; 50 MHz control-register clock.
package slpc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] IDX_SCR_LANE = 12'h58B;
    localparam logic [ADDR_W-1:0] IDX_OCTETS = 12'h58C;
    localparam logic [ADDR_W-1:0] IDX_FRAMES = 12'h58D;
    localparam logic [ADDR_W-1:0] IDX_CONV = 12'h58E;
    localparam logic [ADDR_W-1:0] IDX_CTRL_RES = 12'h58F;
    localparam int SCR_BIT = 7;
    localparam int LANE_LSB = 0;
    localparam int CS_LSB = 6;
    localparam int RES_LSB = 0;
    localparam logic RST_SCR = 1'h1;
    localparam logic [4:0] RST_LANE = 5'h07;
    localparam logic [7:0] RST_OCTETS = 8'h00;
    localparam logic [4:0] RST_FRAMES = 5'h1F;
    localparam logic [7:0] RST_CONV = 8'h01;
    localparam logic [1:0] RST_CS = 2'h0;
    localparam logic [4:0] RST_RES = 5'h0F;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

    typedef struct packed {
        logic [ADDR_W+1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } slpc_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
        logic readdatavalid;
    } slpc_rsp_t;

    // decoded link parameters handed to the transmitter
    typedef struct packed {
        logic scramblerOn;
        logic [3:0] laneCount;
        logic [4:0] octetsPerFrame;
        logic [5:0] framesPerMulti;
        logic [3:0] converterCount;
        logic [1:0] ctrlBits;
        logic [2:0] ctrlBitMask;
        logic [4:0] resolution;
    } slpc_cfg_t;
endpackage : slpc_pkg

/* File: slpc_param_bank.sv */
// slpc_param_bank: register bank of the serial link transport parameters,
// reached over Avalon-MM (word addresses = index * 4, data in byte lane 0).
// assumes: one clock sys_clk at 50 MHz, synchronous active-high sys_rst.
//
// Contract
// - bit 7 enables scrambler when set, disables when clear; resets set.
// - lane field 0,1,3,7 gives 1,2,4,8 lanes; resets to 7.
// - octets per frame is field plus one; resets to zero; linkCfg.octetsPerFrame adds one to octets_q[3:0] only.
// - frames per multiframe is field plus one; resets to 0x1F (32).
// - converter field 0,1,3,7 gives 1,2,4,8 converters; resets to 1.
// - control bits field 0 gives none, 1 gives control bit 2; resets zero.
// - control bits field 2 carries bits 2,1; 3 carries 2,1,0.
// - resolution is field value plus one, e.g. 01101 gives 14 bits; linkCfg.resolution carries the raw field.
`timescale 1ns/100ps
`default_nettype none
module slpc_param_bank
    import slpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire slpc_pkg::slpc_req_t busReq,
    output slpc_pkg::slpc_rsp_t busRsp,
    output slpc_pkg::slpc_cfg_t linkCfg
);
    import slpc_pkg::*;

    // word index and write byte of the request
    logic [ADDR_W-1:0] index;
    logic [7:0] wbyte;
    logic wrLane0;

    // one select per mapped register word
    logic selScrLane;
    logic selOctets;
    logic selFrames;
    logic selConv;
    logic selCtrlRes;
    logic hit;
    logic [7:0] readByte;

    // scrambler and lane count state
    logic scr_q, scr_d;
    logic [4:0] lane_q, lane_d;

    // octets per frame state
    logic [7:0] octets_q, octets_d;

    // frames per multiframe state
    logic [4:0] frames_q, frames_d;

    // converter count state
    logic [7:0] conv_q, conv_d;

    // control bits and resolution state
    logic [1:0] cs_q, cs_d;
    logic [4:0] res_q, res_d;

    // read response state
    logic [31:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic readTaken;

    // decoded fields toward the transmitter
    logic [3:0] laneDecoded;
    logic [3:0] convDecoded;
    logic [2:0] maskDecoded;

    assign index = busReq.address[ADDR_W+1:2];
    assign wbyte = busReq.writedata[7:0];
    // writes with byte lane 0 disabled change nothing
    assign wrLane0 = busReq.write && busReq.byteenable[0];

    assign selScrLane = (index == IDX_SCR_LANE);
    assign selOctets = (index == IDX_OCTETS);
    assign selFrames = (index == IDX_FRAMES);
    assign selConv = (index == IDX_CONV);
    assign selCtrlRes = (index == IDX_CTRL_RES);
    // unmapped words ignore writes and read zero
    assign hit = selScrLane || selOctets || selFrames || selConv || selCtrlRes;

    // readback mux; reserved bits read zero
    always_comb begin
        readByte = 8'h00;
        case (index)
            IDX_SCR_LANE: begin
                readByte = {scr_q, 2'h0, lane_q};
            end
            IDX_OCTETS: begin
                readByte = octets_q;
            end
            IDX_FRAMES: begin
                readByte = {3'h0, frames_q};
            end
            IDX_CONV: begin
                readByte = conv_q;
            end
            IDX_CTRL_RES: begin
                readByte = {cs_q, 1'h0, res_q};
            end
            default: begin
                readByte = 8'h00;
            end
        endcase
    end

    // scrambler and lane count next state
    always_comb begin
        scr_d = scr_q;
        lane_d = lane_q;
        if (sys_rst) begin
            scr_d = RST_SCR;
            lane_d = RST_LANE;
        end else if (wrLane0 && selScrLane) begin
            scr_d = wbyte[SCR_BIT];
            lane_d = wbyte[LANE_LSB +: 5];
        end
    end

    always_ff @(posedge sys_clk) begin
        scr_q <= scr_d;
        lane_q <= lane_d;
    end

    // octets per frame next state
    always_comb begin
        octets_d = octets_q;
        if (sys_rst) begin
            octets_d = RST_OCTETS;
        end else if (wrLane0 && selOctets) begin
            octets_d = wbyte;
        end
    end

    always_ff @(posedge sys_clk) begin
        octets_q <= octets_d;
    end

    // frames per multiframe next state
    always_comb begin
        frames_d = frames_q;
        if (sys_rst) begin
            frames_d = RST_FRAMES;
        end else if (wrLane0 && selFrames) begin
            frames_d = wbyte[4:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        frames_q <= frames_d;
    end

    // converter count next state
    always_comb begin
        conv_d = conv_q;
        if (sys_rst) begin
            conv_d = RST_CONV;
        end else if (wrLane0 && selConv) begin
            conv_d = wbyte;
        end
    end

    always_ff @(posedge sys_clk) begin
        conv_q <= conv_d;
    end

    // control bits and resolution next state
    always_comb begin
        cs_d = cs_q;
        res_d = res_q;
        if (sys_rst) begin
            cs_d = RST_CS;
            res_d = RST_RES;
        end else if (wrLane0 && selCtrlRes) begin
            cs_d = wbyte[CS_LSB +: 2];
            res_d = wbyte[RES_LSB +: 5];
        end
    end

    always_ff @(posedge sys_clk) begin
        cs_q <= cs_d;
        res_q <= res_d;
    end

    // a held read is answered once, so back-to-back reads never see stale data
    assign readTaken = busReq.read && !rvalid_q;

    always_comb begin
        rvalid_d = readTaken;
        rdata_d = rdata_q;
        if (sys_rst) begin
            rvalid_d = 1'b0;
            rdata_d = 32'h00000000;
        end else if (readTaken) begin
            if (hit) begin
                rdata_d = {24'h000000, readByte};
            end else begin
                rdata_d = UNMAPPED_DATA;
            end
        end
    end

    // read data stands until the next read is taken
    always_ff @(posedge sys_clk) begin
        rdata_q <= rdata_d;
        rvalid_q <= rvalid_d;
    end

    // reads wait one cycle for registered data, writes complete at once
    always_comb begin
        busRsp.waitrequest = readTaken;
        busRsp.readdata = rdata_q;
        busRsp.readdatavalid = rvalid_q;
    end

    // lane decode, unlisted codes give eight
    always_comb begin
        case (lane_q)
            5'h00: begin
                laneDecoded = 4'h1;
            end
            5'h01: begin
                laneDecoded = 4'h2;
            end
            5'h03: begin
                laneDecoded = 4'h4;
            end
            default: begin
                laneDecoded = 4'h8;
            end
        endcase
    end

    // converter decode of conv_q[2:0] only, unlisted low-bit codes give eight
    always_comb begin
        case (conv_q[2:0])
            3'h0: begin
                convDecoded = 4'h1;
            end
            3'h1: begin
                convDecoded = 4'h2;
            end
            3'h3: begin
                convDecoded = 4'h4;
            end
            default: begin
                convDecoded = 4'h8;
            end
        endcase
    end

    always_comb begin
        case (cs_q)
            2'h0: begin
                maskDecoded = 3'h0;
            end
            2'h1: begin
                maskDecoded = 3'h4;
            end
            2'h2: begin
                maskDecoded = 3'h6;
            end
            default: begin
                maskDecoded = 3'h7;
            end
        endcase
    end

    // decoded parameters toward the transmitter
    always_comb begin
        linkCfg.scramblerOn = scr_q;
        linkCfg.laneCount = laneDecoded;
        linkCfg.octetsPerFrame = 5'({1'b0, octets_q[3:0]} + 5'h01);
        linkCfg.framesPerMulti = 6'({1'b0, frames_q} + 6'h01);
        linkCfg.converterCount = convDecoded;
        linkCfg.ctrlBits = cs_q;
        linkCfg.ctrlBitMask = maskDecoded;
        linkCfg.resolution = res_q;
    end
endmodule : slpc_param_bank
`default_nettype wire

/* File: slpc_param_bank_properties.sv */
// slpc_param_bank_properties: timing checks on the parameter bank ports.
// assumes: slpc_pkg compiled first; bound to slpc_param_bank below.
`timescale 1ns/100ps
`default_nettype none
module slpc_param_bank_properties
    import slpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire slpc_pkg::slpc_req_t busReq,
    input wire slpc_pkg::slpc_rsp_t busRsp,
    input wire slpc_pkg::slpc_cfg_t linkCfg
);
    import slpc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire logic [11:0] ix = busReq.address[13:2];
    wire logic [7:0] wd = busReq.writedata[7:0];
    wire logic wr = busReq.write && busReq.byteenable[0];
    a_scr_write: assert property (wr && ix == IDX_SCR_LANE |=> linkCfg.scramblerOn == $past(wd[7])) else $error("scr");
    a_lane_four: assert property (wr && ix == IDX_SCR_LANE && wd[4:0] == 5'h03 |=> linkCfg.laneCount == 4'h4) else $error("lane");
    a_octets_plus: assert property (wr && ix == IDX_OCTETS |=> linkCfg.octetsPerFrame == $past(wd[3:0]) + 5'h01) else $error("F");
    a_frames_plus: assert property (wr && ix == IDX_FRAMES |=> linkCfg.framesPerMulti == $past(wd[4:0]) + 6'h01) else $error("K");
    a_conv_eight: assert property (wr && ix == IDX_CONV && wd == 8'h07 |=> linkCfg.converterCount == 4'h8) else $error("M");
    a_cs_low: assert property (linkCfg.ctrlBits < 2'h2 |-> linkCfg.ctrlBitMask == {linkCfg.ctrlBits[0], 2'h0}) else $error("cs");
    a_cs_high: assert property (linkCfg.ctrlBits > 2'h1 |-> linkCfg.ctrlBitMask == {2'h3, linkCfg.ctrlBits[0]}) else $error("cs");
    a_res_write: assert property (wr && ix == IDX_CTRL_RES |=> linkCfg.resolution == $past(wd[4:0])) else $error("N");
    cover property (wr && ix == IDX_CONV);
    cover property (busRsp.readdatavalid);
    cover property (linkCfg.ctrlBits == 2'h3);
endmodule : slpc_param_bank_properties
bind slpc_param_bank slpc_param_bank_properties u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(busReq),
    .busRsp(busRsp), .linkCfg(linkCfg));
`default_nettype wire

/* File: slpc_param_bank_bench.sv */
// slpc_param_bank_bench: random and corner register traffic on the bank.
// assumes: slpc_pkg and the checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module slpc_param_bank_bench;
    import slpc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    slpc_req_t req = '0;
    slpc_rsp_t rsp;
    slpc_cfg_t cfg;
    int err_total = 0;
    int compares = 0;
    int i;
    logic [31:0] seed = 32'd84773;
    logic [31:0] rd;
    logic vld;
    logic [7:0] d;
    logic [7:0] fv [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0F};
    logic [7:0] rv [5] = '{{RST_SCR, 2'h0, RST_LANE}, RST_OCTETS, {3'h0, RST_FRAMES}, RST_CONV, {RST_CS, 1'h0, RST_RES}};
    always #10 sys_clk = ~sys_clk;
    slpc_param_bank dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(req), .busRsp(rsp), .linkCfg(cfg));
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function logic [31:0] maskOf(input logic [1:0] c);
        return {29'h0, |c, c[1], &c};
    endfunction : maskOf
    task tally_and_finish();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, s, e);
        end
    endtask : chk
    task acc(input logic [11:0] x, input logic w, input logic [7:0] v, input logic be);
        int n;
        @(posedge sys_clk);
        req <= '{{x, 2'h0}, !w, w, {24'h0, v}, {3'h0, be}};
        @(posedge sys_clk);
        for (n = 0; n < 9 && rsp.waitrequest !== 1'b0; n++) begin
            @(posedge sys_clk);
        end
        if (n == 9) begin
            err_total++;
            tally_and_finish();
        end
        rd = rsp.readdata;
        vld = rsp.readdatavalid;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(negedge sys_clk);
    endtask : acc
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            acc(IDX_SCR_LANE + 12'(i), 1'b0, 8'h00, 1'b1);
            chk(rd, {24'h0, rv[i]});
            chk(32'(vld), 32'h1);
        end
        // only listed lane and converter codes are written
        for (i = 0; i < 4; i++) begin
            d = (rnd() & 8'h80) | 8'h60 | 8'((1 << i) - 1);
            acc(IDX_SCR_LANE, 1'b1, d, 1'b1);
            chk(32'(cfg.laneCount), 32'(1 << i));
            chk(32'(cfg.scramblerOn), 32'(d[7]));
            acc(IDX_SCR_LANE, 1'b0, 8'h00, 1'b1);
            chk(rd, {24'h0, d & 8'h9F});
            acc(IDX_CONV, 1'b1, {3'h0, d[4:0]}, 1'b1);
            chk(32'(cfg.converterCount), 32'(1 << i));
        end
        acc(IDX_CONV, 1'b1, 8'h03, 1'b0);
        chk(32'(cfg.converterCount), 32'h8);
        for (i = 0; i < 7; i++) begin
            acc(IDX_OCTETS, 1'b1, fv[i], 1'b1);
            chk(32'(cfg.octetsPerFrame), 32'(fv[i]) + 1);
        end
        for (i = 0; i < 4; i++) begin
            // F of 16 keeps any K legal
            d = rnd();
            acc(IDX_FRAMES, 1'b1, d, 1'b1);
            chk(32'(cfg.framesPerMulti), 32'(d[4:0]) + 1);
            d[7:6] = 2'(i);
            acc(IDX_CTRL_RES, 1'b1, d, 1'b1);
            chk(32'(cfg.ctrlBitMask), maskOf(d[7:6]));
            chk(32'(cfg.ctrlBits), 32'(d[7:6]));
            chk(32'(cfg.resolution), 32'(d[4:0]));
            acc(IDX_CTRL_RES, 1'b0, 8'h00, 1'b1);
            chk(rd, {24'h0, d & 8'hDF});
        end
        acc(12'h590, 1'b1, 8'hFF, 1'b1);
        acc(12'h590, 1'b0, 8'h00, 1'b1);
        chk(rd, UNMAPPED_DATA);
        tally_and_finish();
    end
endmodule : slpc_param_bank_bench
`default_nettype wire
